// File: verilog/sysctl_pkg.sv
// Constants, field layouts and carrier types of the system control block
package sysctl_pkg;
  localparam logic [31:0] ADDR_ACTLR = 32'hE000E008;
  localparam logic [31:0] ADDR_CPUID = 32'hE000ED00;
  localparam logic [31:0] ADDR_ICSR = 32'hE000ED04;
  localparam logic [31:0] ADDR_VTOR = 32'hE000ED08;
  localparam logic [31:0] ADDR_AIRCR = 32'hE000ED0C;
  localparam logic [31:0] ADDR_SCR = 32'hE000ED10;
  localparam logic [31:0] ADDR_CCR = 32'hE000ED14;
  localparam logic [31:0] ADDR_SHPR1 = 32'hE000ED18;
  localparam logic [31:0] ADDR_SHPR2 = 32'hE000ED1C;
  localparam logic [31:0] ADDR_SHPR3 = 32'hE000ED20;
  localparam logic [31:0] ADDR_SHCSR = 32'hE000ED24;
  localparam logic [31:0] ADDR_CFSR = 32'hE000ED28;
  localparam logic [31:0] ADDR_HFSR = 32'hE000ED2C;
  localparam logic [31:0] ADDR_MMFAR = 32'hE000ED34;
  localparam logic [31:0] ADDR_BFAR = 32'hE000ED38;
  localparam logic [31:0] ADDR_AFSR = 32'hE000ED3C;
  localparam logic [31:0] ADDR_STIR = 32'hE000EF00;
  localparam logic [31:0] ADDR_EVT_STAT = 32'hE000EF10;
  localparam logic [31:0] ADDR_EVT_MASK = 32'hE000EF14;
  localparam logic [31:0] RST_CCR = 32'h00000200;
  localparam logic [15:0] AIRCR_KEY_WR = 16'h05FA;
  localparam logic [15:0] AIRCR_KEY_RD = 16'hFA05;
  localparam logic [31:0] VTOR_MASK = 32'hFFFFFF80;
  localparam logic [3:0] CPUID_CONST = 4'hF;
  localparam logic [3:0] STRB_WORD = 4'hF;
  localparam logic [8:0] STIR_MAX = 9'h0EF;
  localparam logic [8:0] EXC_NMI = 9'h002;
  localparam logic [8:0] EXC_DEFERRED_SERVICE_EXCEPTION = 9'h00E;
  localparam logic [8:0] EXC_TICK = 9'h00F;
  localparam logic [8:0] IRQ_BASE = 9'h010;
  localparam int ICSR_NMI_SET = 31;
  localparam int ICSR_SV_SET = 28;
  localparam int ICSR_SV_CLR = 27;
  localparam int ICSR_TICK_SET = 26;
  localparam int ICSR_TICK_CLR = 25;
  localparam int ICSR_ISR_PEND = 22;
  localparam int ICSR_RET_BASE = 11;
  localparam int CFSR_MMAR_VALID = 7;
  localparam int CFSR_BFAR_VALID = 15;
  localparam int EVT_W = 4;
  localparam int EVT_MEM_FAULT = 0;
  localparam int EVT_BUS_FAULT = 1;
  localparam int EVT_SW_TRIG = 2;
  localparam int EVT_NMI = 3;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    WR_IDLE = 2'b00,
    WR_RESP = 2'b01
  } wr_state_t;
  typedef enum logic [1:0] {
    RD_IDLE = 2'b00,
    RD_RESP = 2'b01
  } rd_state_t;

  typedef struct packed {
    logic fp_out_of_order_disable;
    logic float_context_update_disable;
    logic cond_block_fold_disable;
    logic default_write_buffer_disable;
    logic multicycle_interrupt_disable;
  } aux_ctrl_t;

  typedef struct packed {
    logic valid;
    logic [31:0] addr;
  } fault_capture_t;

  typedef struct packed {
    logic valid;
    logic [7:0] irq;
    logic [7:0] priority_level;
  } pend_req_t;
endpackage

// File: verilog/system_exception_control_regs.sv
// System control register block with AXI4-Lite slave
module system_exception_control_regs #(
  parameter logic [7:0] IMPLEMENTER = 8'h5A, // arbitrary value
  parameter logic [3:0] VARIANT = 4'h0,
  parameter logic [11:0] PART_NUMBER = 12'h123, // arbitrary value
  parameter logic [3:0] REVISION = 4'h0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [31:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic nmi_signal,
  input wire logic nmi_taken,
  input wire logic deferred_service_taken,
  input wire logic tick_event,
  input wire logic tick_taken,
  input wire sysctl_pkg::fault_capture_t mem_fault,
  input wire sysctl_pkg::fault_capture_t bus_fault,
  input wire sysctl_pkg::pend_req_t ext_pending,
  input wire logic [7:0] base_priority_mask,
  input wire logic fault_mask_reg,
  input wire logic [8:0] active_vector_number,
  input wire logic return_to_base_flag,
  output sysctl_pkg::aux_ctrl_t aux_ctrl,
  output logic trigger_valid,
  output logic [8:0] trigger_irq_number,
  output logic nmi_pending,
  output logic deferred_service_pending,
  output logic tick_pending,
  output logic [8:0] pending_vector_number,
  output logic event_irq
);

  typedef struct packed {
    sysctl_pkg::wr_state_t wst;
    sysctl_pkg::rd_state_t rst;
    logic aw_got;
    logic w_got;
    logic [31:0] aw_addr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    sysctl_pkg::aux_ctrl_t actlr;
    logic [31:0] vtor;
    logic [2:0] prigroup;
    logic [31:0] scr;
    logic [31:0] ccr;
    logic [31:0] shpr1;
    logic [31:0] shpr2;
    logic [31:0] shpr3;
    logic [31:0] shcsr;
    logic [31:0] cfsr;
    logic [31:0] hfsr;
    logic [31:0] mmfar;
    logic [31:0] bfar;
    logic [31:0] afsr;
    logic nmi_pend;
    logic sv_pend;
    logic tick_pend;
    logic isr_flag;
    logic [8:0] pend_vec;
    logic sw_valid;
    logic [8:0] sw_num;
    logic [sysctl_pkg::EVT_W-1:0] evt_stat;
    logic [sysctl_pkg::EVT_W-1:0] evt_mask;
    logic irq;
  } state_t;

  localparam int ICSR_NMI_SET_I = sysctl_pkg::ICSR_NMI_SET;
  localparam int ICSR_SV_SET_I = sysctl_pkg::ICSR_SV_SET;
  localparam int ICSR_SV_CLR_I = sysctl_pkg::ICSR_SV_CLR;
  localparam int ICSR_TICK_SET_I = sysctl_pkg::ICSR_TICK_SET;
  localparam int ICSR_TICK_CLR_I = sysctl_pkg::ICSR_TICK_CLR;
  localparam int ICSR_ISR_I = sysctl_pkg::ICSR_ISR_PEND;
  localparam int ICSR_RET_I = sysctl_pkg::ICSR_RET_BASE;
  localparam int CFSR_MMAR_I = sysctl_pkg::CFSR_MMAR_VALID;
  localparam int CFSR_BFAR_I = sysctl_pkg::CFSR_BFAR_VALID;

  state_t state_reg;
  state_t state_next;

  function automatic logic [31:0] merge(input logic [31:0] old_val,
                                        input logic [31:0] new_val,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_val[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic mapped(input logic [31:0] a);
    logic [31:0] w;
    w = {a[31:2], 2'b00};
    case (w)
      sysctl_pkg::ADDR_ACTLR, sysctl_pkg::ADDR_CPUID, sysctl_pkg::ADDR_ICSR,
      sysctl_pkg::ADDR_VTOR, sysctl_pkg::ADDR_AIRCR, sysctl_pkg::ADDR_SCR,
      sysctl_pkg::ADDR_CCR, sysctl_pkg::ADDR_SHPR1, sysctl_pkg::ADDR_SHPR2,
      sysctl_pkg::ADDR_SHPR3, sysctl_pkg::ADDR_SHCSR, sysctl_pkg::ADDR_CFSR,
      sysctl_pkg::ADDR_HFSR, sysctl_pkg::ADDR_MMFAR, sysctl_pkg::ADDR_BFAR,
      sysctl_pkg::ADDR_AFSR, sysctl_pkg::ADDR_STIR,
      sysctl_pkg::ADDR_EVT_STAT, sysctl_pkg::ADDR_EVT_MASK: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  always_comb begin
    state_t r;
    state_t n;
    logic [31:0] waddr;
    logic [31:0] raddr;
    logic word;
    logic [31:0] icsr;
    logic [31:0] cfsr_clr;
    logic [sysctl_pkg::EVT_W-1:0] ev;
    logic [sysctl_pkg::EVT_W-1:0] rd_clr;
    logic nmi_set;
    logic sv_set;
    logic sv_clr;
    logic tick_set;
    logic tick_clr;
    logic [2:0] c_on;
    logic [7:0] c_pri [3];
    logic [8:0] c_num [3];
    logic found;
    logic [7:0] best;
    logic [8:0] vec;
    r = state_reg;
    n = state_reg;
    waddr = {r.aw_addr[31:2], 2'b00};
    raddr = {araddr[31:2], 2'b00};
    word = (r.wstrb == sysctl_pkg::STRB_WORD);
    cfsr_clr = '0;
    ev = '0;
    rd_clr = '0;
    nmi_set = nmi_signal;
    sv_set = 1'b0;
    sv_clr = 1'b0;
    tick_set = tick_event;
    tick_clr = tick_taken;
    n.sw_valid = 1'b0;

    // Control and state word as software reads it
    icsr = '0;
    icsr[ICSR_NMI_SET_I] = r.nmi_pend;
    icsr[ICSR_SV_SET_I] = r.sv_pend;
    icsr[ICSR_TICK_SET_I] = r.tick_pend;
    icsr[ICSR_ISR_I] = r.isr_flag;
    icsr[20:12] = r.pend_vec;
    icsr[ICSR_RET_I] = return_to_base_flag;
    icsr[8:0] = active_vector_number;

    // Write address and data, taken in either order
    if (awvalid && r.awready) begin
      n.aw_got = 1'b1;
      n.aw_addr = awaddr;
    end
    if (wvalid && r.wready) begin
      n.w_got = 1'b1;
      n.wdata = wdata;
      n.wstrb = wstrb;
    end

    if (r.wst == sysctl_pkg::WR_IDLE && r.aw_got && r.w_got) begin
      n.wst = sysctl_pkg::WR_RESP;
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bresp = mapped(r.aw_addr) ? sysctl_pkg::RESP_OKAY
                                  : sysctl_pkg::RESP_SLVERR;
      case (waddr)
        sysctl_pkg::ADDR_ACTLR: if (word) begin
          n.actlr.fp_out_of_order_disable = r.wdata[9];
          n.actlr.float_context_update_disable = r.wdata[8];
          n.actlr.cond_block_fold_disable = r.wdata[2];
          n.actlr.default_write_buffer_disable = r.wdata[1];
          n.actlr.multicycle_interrupt_disable = r.wdata[0];
        end
        sysctl_pkg::ADDR_ICSR: if (word) begin
          nmi_set = nmi_set | r.wdata[ICSR_NMI_SET_I];
          sv_set = r.wdata[ICSR_SV_SET_I];
          sv_clr = r.wdata[ICSR_SV_CLR_I];
          tick_set = tick_set | r.wdata[ICSR_TICK_SET_I];
          tick_clr = tick_clr | r.wdata[ICSR_TICK_CLR_I];
        end
        sysctl_pkg::ADDR_VTOR: if (word) begin
          n.vtor = r.wdata & sysctl_pkg::VTOR_MASK;
        end
        sysctl_pkg::ADDR_AIRCR: begin
          if (word && r.wdata[31:16] == sysctl_pkg::AIRCR_KEY_WR) begin
            n.prigroup = r.wdata[10:8];
          end
        end
        sysctl_pkg::ADDR_SCR: if (word) n.scr = r.wdata;
        sysctl_pkg::ADDR_CCR: if (word) n.ccr = r.wdata;
        sysctl_pkg::ADDR_SHPR1: n.shpr1 = merge(r.shpr1, r.wdata, r.wstrb);
        sysctl_pkg::ADDR_SHPR2: n.shpr2 = merge(r.shpr2, r.wdata, r.wstrb);
        sysctl_pkg::ADDR_SHPR3: n.shpr3 = merge(r.shpr3, r.wdata, r.wstrb);
        sysctl_pkg::ADDR_SHCSR: if (word) n.shcsr = r.wdata;
        sysctl_pkg::ADDR_CFSR: begin
          cfsr_clr = merge('0, r.wdata, r.wstrb);
        end
        sysctl_pkg::ADDR_HFSR: if (word) n.hfsr = r.wdata;
        sysctl_pkg::ADDR_MMFAR: if (word) n.mmfar = r.wdata;
        sysctl_pkg::ADDR_BFAR: if (word) n.bfar = r.wdata;
        sysctl_pkg::ADDR_AFSR: if (word) n.afsr = r.wdata;
        sysctl_pkg::ADDR_STIR: begin
          if (word && r.wdata[8:0] <= sysctl_pkg::STIR_MAX) begin
            n.sw_valid = 1'b1;
            n.sw_num = r.wdata[8:0];
            ev[sysctl_pkg::EVT_SW_TRIG] = 1'b1;
          end
        end
        sysctl_pkg::ADDR_EVT_MASK: if (word) n.evt_mask = r.wdata[3:0];
        default: ;
      endcase
    end
    if (r.bvalid && bready) begin
      n.wst = sysctl_pkg::WR_IDLE;
    end

    // Read channel
    if (arvalid && r.arready) begin
      n.rst = sysctl_pkg::RD_RESP;
      n.rresp = mapped(araddr) ? sysctl_pkg::RESP_OKAY
                               : sysctl_pkg::RESP_SLVERR;
      n.rdata = '0;
      case (raddr)
        sysctl_pkg::ADDR_ACTLR: begin
          n.rdata[9] = r.actlr.fp_out_of_order_disable;
          n.rdata[8] = r.actlr.float_context_update_disable;
          n.rdata[2] = r.actlr.cond_block_fold_disable;
          n.rdata[1] = r.actlr.default_write_buffer_disable;
          n.rdata[0] = r.actlr.multicycle_interrupt_disable;
        end
        sysctl_pkg::ADDR_CPUID: begin
          n.rdata = {IMPLEMENTER, VARIANT, sysctl_pkg::CPUID_CONST,
                     PART_NUMBER, REVISION};
        end
        sysctl_pkg::ADDR_ICSR: n.rdata = icsr;
        sysctl_pkg::ADDR_VTOR: n.rdata = r.vtor;
        sysctl_pkg::ADDR_AIRCR: begin
          n.rdata = {sysctl_pkg::AIRCR_KEY_RD, 5'h00, r.prigroup, 8'h00};
        end
        sysctl_pkg::ADDR_SCR: n.rdata = r.scr;
        sysctl_pkg::ADDR_CCR: n.rdata = r.ccr;
        sysctl_pkg::ADDR_SHPR1: n.rdata = r.shpr1;
        sysctl_pkg::ADDR_SHPR2: n.rdata = r.shpr2;
        sysctl_pkg::ADDR_SHPR3: n.rdata = r.shpr3;
        sysctl_pkg::ADDR_SHCSR: n.rdata = r.shcsr;
        sysctl_pkg::ADDR_CFSR: n.rdata = r.cfsr;
        sysctl_pkg::ADDR_HFSR: n.rdata = r.hfsr;
        sysctl_pkg::ADDR_MMFAR: n.rdata = r.mmfar;
        sysctl_pkg::ADDR_BFAR: n.rdata = r.bfar;
        sysctl_pkg::ADDR_AFSR: n.rdata = r.afsr;
        sysctl_pkg::ADDR_EVT_STAT: begin
          n.rdata[3:0] = r.evt_stat;
          rd_clr = r.evt_stat;
        end
        sysctl_pkg::ADDR_EVT_MASK: n.rdata[3:0] = r.evt_mask;
        default: ;
      endcase
    end
    if (r.rvalid && rready) begin
      n.rst = sysctl_pkg::RD_IDLE;
    end

    // Fault capture: address and valid flag load together
    if (mem_fault.valid) begin
      n.mmfar = mem_fault.addr;
      ev[sysctl_pkg::EVT_MEM_FAULT] = 1'b1;
    end
    if (bus_fault.valid) begin
      n.bfar = bus_fault.addr;
      ev[sysctl_pkg::EVT_BUS_FAULT] = 1'b1;
    end
    n.cfsr = r.cfsr & ~cfsr_clr;
    n.cfsr[CFSR_MMAR_I] = n.cfsr[CFSR_MMAR_I] | mem_fault.valid;
    n.cfsr[CFSR_BFAR_I] = n.cfsr[CFSR_BFAR_I] | bus_fault.valid;

    // Pending state: clear first, set wins
    ev[sysctl_pkg::EVT_NMI] = nmi_set;
    n.nmi_pend = (r.nmi_pend & ~nmi_taken) | nmi_set;
    n.sv_pend = (r.sv_pend & ~(sv_clr | deferred_service_taken))
                | sv_set;
    n.tick_pend = (r.tick_pend & ~tick_clr) | tick_set;
    n.isr_flag = ext_pending.valid;

    // Highest priority pending vector
    c_on = {ext_pending.valid, r.tick_pend, r.sv_pend};
    c_pri[0] = r.shpr3[23:16];
    c_pri[1] = r.shpr3[31:24];
    c_pri[2] = ext_pending.priority_level;
    c_num[0] = sysctl_pkg::EXC_DEFERRED_SERVICE_EXCEPTION;
    c_num[1] = sysctl_pkg::EXC_TICK;
    c_num[2] = sysctl_pkg::IRQ_BASE + {1'b0, ext_pending.irq};
    found = 1'b0;
    best = '0;
    vec = '0;
    for (int i = 0; i < 3; i++) begin
      if (c_on[i] && !fault_mask_reg && (base_priority_mask == '0
          || c_pri[i] < base_priority_mask)
          && (!found || c_pri[i] < best)) begin
        found = 1'b1;
        best = c_pri[i];
        vec = c_num[i];
      end
    end
    if (r.nmi_pend) begin
      vec = sysctl_pkg::EXC_NMI;
    end
    n.pend_vec = vec;

    // Event status, read clears, new event wins
    n.evt_stat = (r.evt_stat & ~rd_clr) | ev;

    // Reset values; fault addresses are left as they are
    if (!aresetn) begin
      n = '0;
      n.ccr = sysctl_pkg::RST_CCR;
      n.mmfar = r.mmfar;
      n.bfar = r.bfar;
    end

    // Handshake flags follow the state
    n.bvalid = (n.wst == sysctl_pkg::WR_RESP);
    n.rvalid = (n.rst == sysctl_pkg::RD_RESP);
    n.awready = aresetn && !n.aw_got && !n.bvalid;
    n.wready = aresetn && !n.w_got && !n.bvalid;
    n.arready = aresetn && !n.rvalid;
    n.irq = |(n.evt_stat & n.evt_mask);
    state_next = n;
  end

  always_ff @(posedge aclk) begin
    state_reg <= state_next;
  end

  assign awready = state_reg.awready;
  assign wready = state_reg.wready;
  assign bvalid = state_reg.bvalid;
  assign bresp = state_reg.bresp;
  assign arready = state_reg.arready;
  assign rvalid = state_reg.rvalid;
  assign rresp = state_reg.rresp;
  assign rdata = state_reg.rdata;
  assign aux_ctrl = state_reg.actlr;
  assign trigger_valid = state_reg.sw_valid;
  assign trigger_irq_number = state_reg.sw_num;
  assign nmi_pending = state_reg.nmi_pend;
  assign deferred_service_pending = state_reg.sv_pend;
  assign tick_pending = state_reg.tick_pend;
  assign pending_vector_number = state_reg.pend_vec;
  assign event_irq = state_reg.irq;

endmodule

// File: testbench/system_exception_control_regs_monitor.sv
// Concurrent checks on the system control block ports
module system_exception_control_regs_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awready,
  input wire logic bvalid,
  input wire logic nmi_signal,
  input wire logic nmi_taken,
  input wire logic deferred_service_taken,
  input wire logic tick_event,
  input wire logic tick_taken,
  input wire sysctl_pkg::pend_req_t ext_pending,
  input wire sysctl_pkg::aux_ctrl_t aux_ctrl,
  input wire logic trigger_valid,
  input wire logic [8:0] trigger_irq_number,
  input wire logic nmi_pending,
  input wire logic deferred_service_pending,
  input wire logic tick_pending,
  input wire logic [8:0] pending_vector_number
);
  timeunit 1ns;
  timeprecision 100ps;
  logic quiet;
  assign quiet = !(nmi_pending || deferred_service_pending || tick_pending
    || ext_pending.valid);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  trig_range_a: assert property (
    trigger_valid |-> trigger_irq_number <= 9'h0EF)
    else $error("trigger number above range");
  trig_pulse_a: assert property (
    trigger_valid |-> $rose(bvalid) ##1 !trigger_valid)
    else $error("trigger pulse not tied to write response");
  nmi_set_a: assert property (
    nmi_signal && !nmi_taken |=> nmi_pending)
    else $error("nonmaskable signal did not pend");
  nmi_clear_a: assert property (
    nmi_taken && !nmi_signal && awready |=> !nmi_pending)
    else $error("handler entry did not clear nonmaskable pending");
  sv_by_write_a: assert property (
    $rose(deferred_service_pending) |-> bvalid || $past(bvalid))
    else $error("deferred service pended without a write");
  sv_clear_a: assert property (
    deferred_service_taken && awready |=> !deferred_service_pending)
    else $error("deferred service pending not removed");
  tick_set_a: assert property (
    tick_event && !tick_taken |=> tick_pending)
    else $error("tick event did not pend");
  vec_zero_a: assert property (
    quiet [*3] |=> pending_vector_number == 9'h000)
    else $error("pending vector not zero while idle");
  vec_nmi_a: assert property (
    nmi_pending [*2] |=> pending_vector_number == sysctl_pkg::EXC_NMI)
    else $error("pending vector not nonmaskable number");
  aux_write_a: assert property (
    !$stable(aux_ctrl) |-> bvalid || $past(bvalid))
    else $error("auxiliary control changed without a write");
  trig_cov: cover property (trigger_valid);
  nmi_cov: cover property ($rose(nmi_pending));
  tick_cov: cover property ($rose(tick_pending));
endmodule

bind system_exception_control_regs system_exception_control_regs_monitor mon (
  .aclk, .aresetn, .awready, .bvalid, .nmi_signal, .nmi_taken,
  .deferred_service_taken, .tick_event, .tick_taken, .ext_pending,
  .aux_ctrl, .trigger_valid, .trigger_irq_number, .nmi_pending,
  .deferred_service_pending, .tick_pending, .pending_vector_number
);

// File: testbench/system_exception_control_regs_test.sv
// Self-checking testbench for the system control register block
module system_exception_control_regs_test;
  timeunit 1ns;
  timeprecision 100ps;
  // Arbitrary identity values
  localparam logic [7:0] IMPL_ID = 8'h3C;
  localparam logic [3:0] VAR_ID = 4'h2;
  localparam logic [11:0] PART_ID = 12'h9A6;
  localparam logic [3:0] REV_ID = 4'h7;
  localparam logic [31:0] ICSR = 32'hE000ED04;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0;
  logic [3:0] wstrb = '0;
  logic [2:0] awprot = '0, arprot = '0;
  logic nmi_signal = 1'b0, nmi_taken = 1'b0, deferred_service_taken = 1'b0;
  logic tick_event = 1'b0, tick_taken = 1'b0, fault_mask_reg = 1'b0;
  logic return_to_base_flag = 1'b0;
  logic [7:0] base_priority_mask = '0;
  logic [8:0] active_vector_number = '0;
  sysctl_pkg::fault_capture_t mem_fault = '0, bus_fault = '0;
  sysctl_pkg::pend_req_t ext_pending = '0;
  logic awready, wready, bvalid, arready, rvalid, trigger_valid, event_irq;
  logic nmi_pending, deferred_service_pending, tick_pending, tv;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [8:0] trigger_irq_number, pending_vector_number, tn;
  sysctl_pkg::aux_ctrl_t aux_ctrl;
  int n_errors = 0;
  int checked = 0;
  logic [8:0] ids [4] = '{9'h000, 9'h0EF, 9'h0F0, 9'h1FF};

  system_exception_control_regs #(.IMPLEMENTER(IMPL_ID), .VARIANT(VAR_ID),
    .PART_NUMBER(PART_ID), .REVISION(REV_ID)) uut (
    .aclk, .aresetn, .awaddr, .awprot, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .nmi_signal, .nmi_taken,
    .deferred_service_taken, .tick_event, .tick_taken, .mem_fault,
    .bus_fault, .ext_pending, .base_priority_mask, .fault_mask_reg,
    .active_vector_number, .return_to_base_flag, .aux_ctrl, .trigger_valid,
    .trigger_irq_number, .nmi_pending, .deferred_service_pending,
    .tick_pending, .pending_vector_number, .event_irq
  );

  always #2 aclk = ~aclk;

  function automatic logic [31:0] rst_exp(int i);
    case (i)
      0: return {IMPL_ID, VAR_ID, 4'hF, PART_ID, REV_ID};
      3: return 32'hFA050000;
      5: return 32'h00000200;
      default: return 32'h00000000;
    endcase
  endfunction

  function automatic logic [31:0] icsr_exp(logic n, s, t, logic [8:0] v);
    return {n, 2'b00, s, 1'b0, t, 3'b000, ext_pending.valid, 1'b0, v,
      return_to_base_flag, 2'b00, active_vector_number};
  endfunction

  task automatic chk(input logic [31:0] got, exp, input string m);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, m, got,
        exp);
    end
  endtask

  task automatic wr(input logic [31:0] a, d, input logic [3:0] s = 4'hF,
    input logic [1:0] er = 2'b00);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    tv = trigger_valid;
    tn = trigger_irq_number;
    bready <= 1'b0;
    chk(32'(bvalid), 32'h1, "write answer");
    chk(32'(bresp), 32'(er), "write response");
  endtask

  task automatic rchk(input logic [31:0] a, e, input logic [1:0] er = 2'b00);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    chk(32'(rvalid), 32'h1, "read answer");
    chk(rdata, e, "read data");
    chk(32'(rresp), 32'(er), "read response");
  endtask

  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge aclk);
    n_errors++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    summarize();
  end

  initial begin
    logic [31:0] a, b, d;
    logic [8:0] id;
    void'($urandom(32'hD9EDC91F));
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    for (int i = 0; i < 16; i++) begin
      a = 32'hE000ED00 + 32'(4 * i);
      if (i != 13 && i != 14) rchk(a, rst_exp(i), {i == 12, 1'b0});
    end
    rchk(32'hE000E008, 32'h0);
    rchk(sysctl_pkg::ADDR_STIR, 32'h0);
    wr(32'hE000ED00, $urandom);
    rchk(32'hE000ED00, rst_exp(0));
    wr(32'hE000ED30, $urandom, 4'hF, 2'b10);
    wr(32'hE000ED0C, 32'h00000700);
    rchk(32'hE000ED0C, 32'hFA050000);
    wr(32'hE000ED0C, 32'h05FA0300);
    rchk(32'hE000ED0C, 32'hFA050300);
    d = $urandom;
    wr(32'hE000ED08, d);
    rchk(32'hE000ED08, d & 32'hFFFFFF80);
    $display("test reset values done");
    for (int k = 0; k < 6; k++) begin
      d = (k == 0) ? 32'hFFFFFFFF : $urandom;
      wr(32'hE000E008, d);
      rchk(32'hE000E008, d & 32'h00000307);
      a = {27'h0, d[9:8], d[2:0]};
      chk(32'(aux_ctrl), a, "aux");
    end
    $display("test auxiliary control done");
    wr(sysctl_pkg::ADDR_EVT_MASK, 32'h5);
    a = $urandom;
    b = $urandom;
    bus_fault <= {1'b1, b};
    @(posedge aclk);
    bus_fault <= '0;
    repeat (3) @(posedge aclk);
    chk(32'(event_irq), 32'h0, "masked event");
    mem_fault <= {1'b1, a};
    @(posedge aclk);
    mem_fault <= '0;
    repeat (3) @(posedge aclk);
    chk(32'(event_irq), 32'h1, "unmasked event");
    rchk(32'hE000ED28, 32'h00008080);
    rchk(32'hE000ED34, a);
    rchk(32'hE000ED38, b);
    wr(32'hE000ED28, 32'h0000FF80, 4'h1);
    rchk(32'hE000ED28, 32'h00008000);
    rchk(sysctl_pkg::ADDR_EVT_STAT, 32'h3);
    repeat (2) @(posedge aclk);
    chk(32'(event_irq), 32'h0, "event cleared");
    rchk(sysctl_pkg::ADDR_EVT_STAT, 32'h0);
    $display("test faults and events done");
    active_vector_number <= 9'($urandom);
    return_to_base_flag <= 1'b1;
    wr(ICSR, 32'h10000000);
    rchk(ICSR, icsr_exp(0, 1, 0, 9'd14));
    wr(ICSR, 32'h04000000);
    rchk(ICSR, icsr_exp(0, 1, 1, 9'd14));
    wr(32'hE000ED20, 32'h00800000, 4'h4);
    rchk(ICSR, icsr_exp(0, 1, 1, 9'd15));
    fault_mask_reg <= 1'b1;
    repeat (2) @(posedge aclk);
    rchk(ICSR, icsr_exp(0, 1, 1, 9'd0));
    fault_mask_reg <= 1'b0;
    wr(ICSR, 32'h0A000000);
    rchk(ICSR, icsr_exp(0, 0, 0, 9'd0));
    wr(ICSR, 32'h80000000);
    rchk(ICSR, icsr_exp(1, 0, 0, 9'd2));
    for (int k = 0; k < 3; k++) begin
      nmi_taken <= (k != 1);
      nmi_signal <= (k == 1);
      @(posedge aclk);
      nmi_taken <= 1'b0;
      nmi_signal <= 1'b0;
      repeat (2) @(posedge aclk);
      rchk(ICSR, icsr_exp(k == 1, 0, 0, {7'h0, k == 1, 1'b0}));
    end
    wr(ICSR, 32'h10000000);
    deferred_service_taken <= 1'b1;
    @(posedge aclk);
    deferred_service_taken <= 1'b0;
    repeat (2) @(posedge aclk);
    chk(32'(deferred_service_pending), 32'h0, "service taken");
    ext_pending <= {1'b1, 8'h05, 8'h10};
    tick_event <= 1'b1;
    @(posedge aclk);
    tick_event <= 1'b0;
    repeat (2) @(posedge aclk);
    rchk(ICSR, icsr_exp(0, 0, 1, 9'd15));
    chk(32'(pending_vector_number), 32'd15, "vector port");
    tick_taken <= 1'b1;
    @(posedge aclk);
    tick_taken <= 1'b0;
    repeat (2) @(posedge aclk);
    rchk(ICSR, icsr_exp(0, 0, 0, 9'd21));
    ext_pending <= '0;
    $display("test pending state done");
    for (int k = 0; k < 8; k++) begin
      id = (k < 4) ? ids[k] : 9'($urandom_range(0, 300));
      wr(sysctl_pkg::ADDR_STIR, {23'($urandom), id});
      chk(32'(tv), 32'(id <= 9'd239), "trigger pulse");
      if (id <= 9'd239) chk(32'(tn), 32'(id), "trigger number");
    end
    chk(32'(event_irq), 32'h1, "trigger event");
    rchk(sysctl_pkg::ADDR_EVT_STAT, 32'hC);
    $display("test software trigger done");
    summarize();
  end
endmodule
